/* shared/iebs_pkg.sv */
// Shared constants for the two-wire bus enable and bus-state control ends
package iebs_pkg;
  // Link clock divider: clk_in cycles per half period of the link clock, less one
  localparam logic [1:0] LINK_HALF_CYC = 2'h3;
  // Host bit phase length in clk_in cycles less one; the midpoint count marks data setup
  localparam logic [6:0] PHASE_LAST = 7'h3F;
  localparam logic [6:0] PHASE_MID = 7'h20;
  // Bus must look idle this many clk_in cycles before a start
  localparam logic [7:0] FREE_LAST = 8'hFF;
  // Bit counter landmarks inside one byte
  localparam logic [3:0] BIT_EIGHTH = 4'h8;
  localparam logic [3:0] BIT_NINTH = 4'h9;
  // Extension code: upper nibble of the first byte after a start
  localparam logic [3:0] EXT_CODE_HI = 4'hF;
  localparam logic [3:0] EXT_CODE_LO = 4'h0;
  // Link cycles, less one, the device holds data low with clock high before releasing
  localparam logic [3:0] STOP_HOLD_LAST = 4'h4;
  // Receive buffer depth
  localparam logic [1:0] BUF_DEPTH = 2'h2;
  // Device stop generator states
  typedef enum logic [1:0] {
    IEBS_SG_IDLE = 2'b00,
    IEBS_SG_LOW = 2'b01,
    IEBS_SG_WAIT = 2'b10,
    IEBS_SG_HOLD = 2'b11
  } iebs_stopgen_t;
  // Host master states
  typedef enum logic [3:0] {
    IEBS_H_IDLE = 4'b0000,
    IEBS_H_FREE = 4'b0001,
    IEBS_H_START = 4'b0010,
    IEBS_H_LOW = 4'b0011,
    IEBS_H_HIGH = 4'b0100,
    IEBS_H_NEXT = 4'b0101,
    IEBS_H_STOP1 = 4'b0110,
    IEBS_H_STOP2 = 4'b0111,
    IEBS_H_STOP3 = 4'b1000
  } iebs_hstate_t;
endpackage : iebs_pkg

/* shared/iebs_if.sv */
// Two-wire bus carrier joining the device end and the far master end
`timescale 1ns/1ns
`default_nettype none
interface iebs_if;
  logic link_clk;
  logic dev_scl_out;
  logic dev_scl_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic hst_scl_out;
  logic hst_scl_oe;
  logic hst_sda_out;
  logic hst_sda_oe;
  logic scl;
  logic sda;
  // Open-drain lines with pull-up: low while any end drives a low
  assign scl = ~((dev_scl_oe & ~dev_scl_out) | (hst_scl_oe & ~hst_scl_out));
  assign sda = ~((dev_sda_oe & ~dev_sda_out) | (hst_sda_oe & ~hst_sda_out));
  modport dev (
    input link_clk,
    input scl,
    input sda,
    output dev_scl_out,
    output dev_scl_oe,
    output dev_sda_out,
    output dev_sda_oe
  );
  modport hst (
    output link_clk,
    input scl,
    input sda,
    output hst_scl_out,
    output hst_scl_oe,
    output hst_sda_out,
    output hst_sda_oe
  );
endinterface : iebs_if
`default_nettype wire

/* design/iebs_device.sv */
// Device end: bus enable, bus-busy tracking, transfer interrupt timing, receive path
//
// Operation
// - Transfer clock always main clock; divider select ignored
// - Enabling mid-traffic may detect a start
// - Enable only with both lines high
// - Wait bit 1: interrupt at ninth falling
// - Wait 0, extension address: interrupt at eighth
// - Master with arbitration: enable stop interrupt
// - Option 0: busy reported right after enable
// - Option 0: issue stop before master traffic
// - Stop sequence: clock setup, enable, stop request
// - Option 1: released reported right after enable
// - Option 1: confirm bus free before start
`timescale 1ns/1ns
`default_nettype none
module iebs_device (
  // System
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Bus
  iebs_if.dev bus,
  // Control
  input wire logic interface_enable_bit_in,
  input wire logic startup_bus_free_option_in,
  input wire logic wait_timing_bit_in,
  input wire logic stop_irq_enable_bit_in,
  input wire logic stop_request_bit_in,
  input wire logic [7:0] division_clock_select_1_in,
  // Status and events
  output logic bus_busy_flag_out,
  output logic transfer_irq_out,
  output logic stop_irq_out,
  output logic start_seen_out,
  // Received bytes
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  input wire logic rx_ready_in
);
  typedef struct packed {
    logic scl_s1, scl_s2, sda_s1, sda_s2;
    logic en_s1, en_s2, wt_s1, wt_s2;
    logic ack_s1, ack_s2, stq_s1, stq_s2;
    logic scl_d, sda_d;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] byte_q;
    logic first, in_frame, early, hold, drv_ack;
    logic start_t, stop_t, irq_t, byte_t, stq_seen;
    iebs_pkg::iebs_stopgen_t sg;
    logic [3:0] sg_cnt;
    logic stop_drv;
  } iebs_link_t;

  typedef struct packed {
    logic en, opt, wt;
    logic [2:0] st_sync, sp_sync, irq_sync;
    logic by_s1, by_s2, ack_t, stq_t;
    logic busy, irq, spi, sts;
    logic [7:0] e0, e1;
    logic [1:0] cnt;
    logic valid;
  } iebs_core_t;

  iebs_link_t l, l_nxt;
  iebs_core_t c, c_nxt;

  logic rise, fall, start_det, stop_det, ext, irq8;
  logic en_rise, st_edge, sp_edge, irq_edge, pending, push, pop;

  // Link-clock side: line sampling and byte framing
  always_comb begin
    l_nxt = l;
    l_nxt.scl_s1 = bus.scl;
    l_nxt.scl_s2 = l.scl_s1;
    l_nxt.sda_s1 = bus.sda;
    l_nxt.sda_s2 = l.sda_s1;
    l_nxt.en_s1 = c.en;
    l_nxt.en_s2 = l.en_s1;
    l_nxt.wt_s1 = c.wt;
    l_nxt.wt_s2 = l.wt_s1;
    l_nxt.ack_s1 = c.ack_t;
    l_nxt.ack_s2 = l.ack_s1;
    l_nxt.stq_s1 = c.stq_t;
    l_nxt.stq_s2 = l.stq_s1;
    l_nxt.scl_d = l.scl_s2;
    l_nxt.sda_d = l.sda_s2;
    rise = l.scl_s2 & ~l.scl_d;
    fall = ~l.scl_s2 & l.scl_d;
    start_det = l.scl_s2 & l.scl_d & ~l.sda_s2 & l.sda_d;
    stop_det = l.scl_s2 & l.scl_d & l.sda_s2 & ~l.sda_d;
    ext = l.first & ((l.shreg[7:4] == iebs_pkg::EXT_CODE_HI) | (l.shreg[7:4] == iebs_pkg::EXT_CODE_LO));
    irq8 = ~l.wt_s2 & ext;
    if (!l.en_s2) begin
      // Disabled: framing idle, lines released, stop requests tracked not acted on
      l_nxt.cnt = 4'h0;
      l_nxt.shreg = 8'h00;
      l_nxt.byte_q = 8'h00;
      l_nxt.first = 1'b0;
      l_nxt.in_frame = 1'b0;
      l_nxt.early = 1'b0;
      l_nxt.hold = 1'b0;
      l_nxt.drv_ack = 1'b0;
      l_nxt.start_t = 1'b0;
      l_nxt.stop_t = 1'b0;
      l_nxt.irq_t = 1'b0;
      l_nxt.byte_t = 1'b0;
      l_nxt.stq_seen = l.stq_s2;
      l_nxt.sg = iebs_pkg::IEBS_SG_IDLE;
      l_nxt.sg_cnt = 4'h0;
      l_nxt.stop_drv = 1'b0;
    end else begin
      // Detector live from enable, may catch a start mid-traffic
      if (start_det) begin
        l_nxt.start_t = ~l.start_t;
        l_nxt.in_frame = 1'b1;
        l_nxt.first = 1'b1;
        l_nxt.cnt = 4'h0;
        l_nxt.drv_ack = 1'b0;
      end else if (stop_det) begin
        l_nxt.stop_t = ~l.stop_t;
        l_nxt.in_frame = 1'b0;
        l_nxt.drv_ack = 1'b0;
      end else if (l.in_frame) begin
        if (rise && l.cnt < iebs_pkg::BIT_NINTH) begin
          if (l.cnt < iebs_pkg::BIT_EIGHTH) begin
            l_nxt.shreg = {l.shreg[6:0], l.sda_s2};
          end
          l_nxt.cnt = l.cnt + 4'h1;
        end
        if (fall && l.cnt == iebs_pkg::BIT_EIGHTH) begin
          l_nxt.byte_q = l.shreg;
          l_nxt.byte_t = ~l.byte_t;
          l_nxt.drv_ack = 1'b1;
          l_nxt.early = irq8;
          // Interrupt and wait at eighth falling
          if (irq8) begin
            l_nxt.irq_t = ~l.irq_t;
            l_nxt.hold = 1'b1;
          end
        end
        if (fall && l.cnt == iebs_pkg::BIT_NINTH) begin
          l_nxt.drv_ack = 1'b0;
          l_nxt.first = 1'b0;
          l_nxt.cnt = 4'h0;
          // Interrupt and wait at ninth falling
          if (!l.early) begin
            l_nxt.irq_t = ~l.irq_t;
            l_nxt.hold = 1'b1;
          end
        end
      end
      // Clock released only once the byte sits in the buffer
      if (l.hold && (l.ack_s2 == l.byte_t) && !(fall && l.in_frame)) begin
        l_nxt.hold = 1'b0;
      end
      // Stop generation: data low while clock low, release while high
      case (l.sg)
        iebs_pkg::IEBS_SG_IDLE: begin
          if ((l.stq_s2 != l.stq_seen) && !l.scl_s2) begin
            l_nxt.stop_drv = 1'b1;
            l_nxt.sg = iebs_pkg::IEBS_SG_LOW;
          end
        end
        iebs_pkg::IEBS_SG_LOW: begin
          l_nxt.sg = iebs_pkg::IEBS_SG_WAIT;
        end
        iebs_pkg::IEBS_SG_WAIT: begin
          l_nxt.sg_cnt = 4'h0;
          if (l.scl_s2) begin
            l_nxt.sg = iebs_pkg::IEBS_SG_HOLD;
          end
        end
        iebs_pkg::IEBS_SG_HOLD: begin
          l_nxt.sg_cnt = l.sg_cnt + 4'h1;
          if (l.sg_cnt == iebs_pkg::STOP_HOLD_LAST) begin
            l_nxt.stop_drv = 1'b0;
            l_nxt.stq_seen = l.stq_s2;
            l_nxt.sg = iebs_pkg::IEBS_SG_IDLE;
          end
        end
        default: begin
          l_nxt.sg = iebs_pkg::IEBS_SG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge bus.link_clk) begin
    l <= l_nxt;
  end

  assign bus.dev_scl_out = 1'b0;
  assign bus.dev_sda_out = 1'b0;
  assign bus.dev_scl_oe = l.hold;
  assign bus.dev_sda_oe = l.drv_ack | l.stop_drv;

  // Main-clock side: control, busy flag, events, receive buffer
  always_comb begin
    c_nxt = c;
    c_nxt.en = interface_enable_bit_in;
    c_nxt.wt = wait_timing_bit_in;
    // Option latched only while stopped, so a live change cannot glitch busy
    if (!c.en) begin
      c_nxt.opt = startup_bus_free_option_in;
    end
    c_nxt.st_sync = {c.st_sync[1:0], l.start_t};
    c_nxt.sp_sync = {c.sp_sync[1:0], l.stop_t};
    c_nxt.irq_sync = {c.irq_sync[1:0], l.irq_t};
    c_nxt.by_s1 = l.byte_t;
    c_nxt.by_s2 = c.by_s1;
    en_rise = interface_enable_bit_in & ~c.en;
    st_edge = c.en & (c.st_sync[2] ^ c.st_sync[1]);
    sp_edge = c.en & (c.sp_sync[2] ^ c.sp_sync[1]);
    irq_edge = c.en & (c.irq_sync[2] ^ c.irq_sync[1]);
    c_nxt.irq = irq_edge;
    c_nxt.sts = st_edge;
    // Stop event reaches software only when enabled
    c_nxt.spi = sp_edge & stop_irq_enable_bit_in;
    if (!c.en) begin
      c_nxt.busy = 1'b0;
    end else if (st_edge) begin
      c_nxt.busy = 1'b1;
    end else if (sp_edge) begin
      c_nxt.busy = 1'b0;
    end
    if (en_rise) begin
      c_nxt.busy = ~c.opt;
    end
    // Stop request honoured only once enabled
    if (stop_request_bit_in && c.en) begin
      c_nxt.stq_t = ~c.stq_t;
    end
    pending = c.by_s2 != c.ack_t;
    pop = c.valid & rx_ready_in;
    push = c.en & pending & ((c.cnt != iebs_pkg::BUF_DEPTH) | pop);
    if (!c.en) begin
      c_nxt.ack_t = c.by_s2;
    end else if (push) begin
      c_nxt.ack_t = ~c.ack_t;
    end
    case ({push, pop})
      2'b10: begin
        if (c.cnt == 2'h0) begin
          c_nxt.e0 = l.byte_q;
        end else begin
          c_nxt.e1 = l.byte_q;
        end
        c_nxt.cnt = c.cnt + 2'h1;
      end
      2'b01: begin
        c_nxt.e0 = c.e1;
        c_nxt.cnt = c.cnt - 2'h1;
      end
      2'b11: begin
        if (c.cnt == 2'h1) begin
          c_nxt.e0 = l.byte_q;
        end else begin
          c_nxt.e0 = c.e1;
          c_nxt.e1 = l.byte_q;
        end
      end
      default: begin
        c_nxt.cnt = c.cnt;
      end
    endcase
    c_nxt.valid = c_nxt.cnt != 2'h0;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      c <= '0;
    end else begin
      c <= c_nxt;
    end
  end

  assign bus_busy_flag_out = c.busy;
  assign transfer_irq_out = c.irq;
  assign stop_irq_out = c.spi;
  assign start_seen_out = c.sts;
  assign rx_valid_out = c.valid;
  assign rx_data_out = c.e0;
endmodule : iebs_device
`default_nettype wire

/* design/iebs_host.sv */
// Far end: bus master that makes the link clock and writes bytes to the device
`timescale 1ns/1ns
`default_nettype none
module iebs_host (
  // System
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Bus
  iebs_if.hst bus,
  // Bytes to send
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_last_in,
  output logic tx_ready_out,
  // Status
  output logic nack_out,
  output logic busy_out
);
  typedef struct packed {
    logic [1:0] div;
    logic lclk;
    logic scl_s1, scl_s2, sda_s1, sda_s2;
    iebs_pkg::iebs_hstate_t st;
    logic [6:0] ph;
    logic [7:0] free_cnt;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic last, scl_oe, sda_oe, ready, nack, busy;
  } iebs_host_t;

  iebs_host_t h, h_nxt;
  logic take, ph_end;

  always_comb begin
    h_nxt = h;
    h_nxt.div = h.div + 2'h1;
    if (h.div == iebs_pkg::LINK_HALF_CYC) begin
      h_nxt.div = 2'h0;
      h_nxt.lclk = ~h.lclk;
    end
    h_nxt.scl_s1 = bus.scl;
    h_nxt.scl_s2 = h.scl_s1;
    h_nxt.sda_s1 = bus.sda;
    h_nxt.sda_s2 = h.sda_s1;
    take = tx_valid_in & h.ready;
    ph_end = h.ph == iebs_pkg::PHASE_LAST;
    h_nxt.ph = ph_end ? 7'h00 : h.ph + 7'h01;
    h_nxt.nack = 1'b0;
    case (h.st)
      iebs_pkg::IEBS_H_IDLE: begin
        h_nxt.scl_oe = 1'b0;
        h_nxt.sda_oe = 1'b0;
        h_nxt.ready = ~take;
        if (take) begin
          h_nxt.shreg = tx_data_in;
          h_nxt.last = tx_last_in;
          h_nxt.free_cnt = 8'h00;
          h_nxt.st = iebs_pkg::IEBS_H_FREE;
        end
      end
      iebs_pkg::IEBS_H_FREE: begin
        // Start only after both lines stay high
        h_nxt.ph = 7'h00;
        h_nxt.free_cnt = (h.scl_s2 & h.sda_s2) ? h.free_cnt + 8'h01 : 8'h00;
        if (h.free_cnt == iebs_pkg::FREE_LAST) begin
          h_nxt.st = iebs_pkg::IEBS_H_START;
        end
      end
      iebs_pkg::IEBS_H_START: begin
        h_nxt.sda_oe = 1'b1;
        if (ph_end) begin
          h_nxt.bit_cnt = 4'h0;
          h_nxt.st = iebs_pkg::IEBS_H_LOW;
        end
      end
      iebs_pkg::IEBS_H_LOW: begin
        h_nxt.scl_oe = 1'b1;
        if (h.ph == iebs_pkg::PHASE_MID) begin
          h_nxt.sda_oe = (h.bit_cnt < iebs_pkg::BIT_EIGHTH) ? ~h.shreg[7] : 1'b0;
        end
        if (ph_end) begin
          h_nxt.st = iebs_pkg::IEBS_H_HIGH;
        end
      end
      iebs_pkg::IEBS_H_HIGH: begin
        h_nxt.scl_oe = 1'b0;
        // Clock stretched by the device holds the phase at zero, so it restarts on release
        if (!h.scl_s2) begin
          h_nxt.ph = 7'h00;
        end else if (ph_end) begin
          if (h.bit_cnt == iebs_pkg::BIT_EIGHTH) begin
            h_nxt.nack = h.sda_s2;
            h_nxt.scl_oe = 1'b1;
            if (h.last || h.sda_s2) begin
              h_nxt.st = iebs_pkg::IEBS_H_STOP1;
            end else begin
              h_nxt.ready = 1'b1;
              h_nxt.st = iebs_pkg::IEBS_H_NEXT;
            end
          end else begin
            h_nxt.shreg = {h.shreg[6:0], 1'b0};
            h_nxt.bit_cnt = h.bit_cnt + 4'h1;
            h_nxt.st = iebs_pkg::IEBS_H_LOW;
          end
        end
      end
      iebs_pkg::IEBS_H_NEXT: begin
        h_nxt.scl_oe = 1'b1;
        h_nxt.ph = 7'h00;
        if (take) begin
          h_nxt.ready = 1'b0;
          h_nxt.shreg = tx_data_in;
          h_nxt.last = tx_last_in;
          h_nxt.bit_cnt = 4'h0;
          h_nxt.st = iebs_pkg::IEBS_H_LOW;
        end
      end
      iebs_pkg::IEBS_H_STOP1: begin
        h_nxt.scl_oe = 1'b1;
        if (h.ph == iebs_pkg::PHASE_MID) begin
          h_nxt.sda_oe = 1'b1;
        end
        if (ph_end) begin
          h_nxt.st = iebs_pkg::IEBS_H_STOP2;
        end
      end
      iebs_pkg::IEBS_H_STOP2: begin
        h_nxt.scl_oe = 1'b0;
        if (!h.scl_s2) begin
          h_nxt.ph = 7'h00;
        end else if (ph_end) begin
          h_nxt.st = iebs_pkg::IEBS_H_STOP3;
        end
      end
      iebs_pkg::IEBS_H_STOP3: begin
        h_nxt.sda_oe = 1'b0;
        if (ph_end) begin
          h_nxt.ready = 1'b1;
          h_nxt.st = iebs_pkg::IEBS_H_IDLE;
        end
      end
      default: begin
        h_nxt.st = iebs_pkg::IEBS_H_IDLE;
      end
    endcase
    h_nxt.busy = h_nxt.st != iebs_pkg::IEBS_H_IDLE;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      h <= '0;
    end else begin
      h <= h_nxt;
    end
  end

  assign bus.link_clk = h.lclk;
  assign bus.hst_scl_out = 1'b0;
  assign bus.hst_sda_out = 1'b0;
  assign bus.hst_scl_oe = h.scl_oe;
  assign bus.hst_sda_oe = h.sda_oe;
  assign tx_ready_out = h.ready;
  assign nack_out = h.nack;
  assign busy_out = h.busy;
endmodule : iebs_host
`default_nettype wire

/* tb/iebs_sva.sv */
// Assertion checker for the device and host ends of the two-wire link
`timescale 1ns/1ns
`default_nettype none
module iebs_sva (
  // System
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Lines
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic hst_sda_oe,
  // Device control and status
  input wire logic interface_enable_bit_in,
  input wire logic startup_bus_free_option_in,
  input wire logic wait_timing_bit_in,
  input wire logic stop_irq_enable_bit_in,
  input wire logic bus_busy_flag_out,
  input wire logic transfer_irq_out,
  input wire logic stop_irq_out,
  input wire logic start_seen_out,
  input wire logic rx_valid_out,
  input wire logic [7:0] rx_data_out,
  input wire logic rx_ready_in
);
  logic scl_r;
  logic sda_r;
  logic [3:0] bit_idx;
  logic [7:0] off_cnt;
  logic [8:0] free_cnt;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Clock index in a byte: F at start, 0 on the fall that ends it, then 1..9
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      bit_idx <= 4'h0;
      off_cnt <= 8'h00;
      free_cnt <= 9'h000;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
      if (scl && scl_r && sda_r && !sda) begin
        bit_idx <= 4'hF;
      end else if (scl_r && !scl) begin
        bit_idx <= (bit_idx == 4'h9) ? 4'h1 : bit_idx + 4'h1;
      end
      // Saturate so long idle stretches never wrap
      off_cnt <= interface_enable_bit_in ? 8'h00 : ((off_cnt == 8'hFF) ? off_cnt : off_cnt + 8'h01);
      // Unsettled lines right after reset count as busy, so the idle count starts clean
      if (scl && sda) begin
        free_cnt <= (free_cnt == 9'h1FF) ? free_cnt : free_cnt + 9'h001;
      end else begin
        free_cnt <= 9'h000;
      end
    end
  end
  AST_BUSY_AFT_EN_0: assert property (
    $rose(interface_enable_bit_in) && !startup_bus_free_option_in |-> ##[1:2] bus_busy_flag_out)
    else $error("busy not reported after enable");
  AST_FREE_AFT_EN_1: assert property (
    $rose(interface_enable_bit_in) && startup_bus_free_option_in |-> ##[1:2] !bus_busy_flag_out ##1 !bus_busy_flag_out)
    else $error("released not reported after enable");
  AST_BUSY_ON_START: assert property (
    start_seen_out |-> ##[0:1] bus_busy_flag_out)
    else $error("busy not set on start");
  AST_FREE_ON_STOP: assert property (
    stop_irq_out |-> ##[0:1] !bus_busy_flag_out)
    else $error("busy not cleared on stop");
  AST_STOP_IRQ_MASK: assert property (
    stop_irq_out |-> stop_irq_enable_bit_in)
    else $error("stop event while masked");
  AST_QUIET_OFF: assert property (
    off_cnt >= 8'h64 |-> !start_seen_out && !transfer_irq_out && !stop_irq_out && !bus_busy_flag_out)
    else $error("event while disabled");
  AST_NO_DRIVE_OFF: assert property (
    off_cnt >= 8'h64 |-> !dev_scl_oe && !dev_sda_oe)
    else $error("line driven while disabled");
  AST_IRQ_NINTH: assert property (
    transfer_irq_out && wait_timing_bit_in |-> bit_idx == 4'h9)
    else $error("transfer event not at ninth fall");
  AST_IRQ_EIGHTH: assert property (
    transfer_irq_out && !wait_timing_bit_in |-> bit_idx == 4'h8 || bit_idx == 4'h9)
    else $error("transfer event off eighth or ninth fall");
  AST_RX_HOLD: assert property (
    rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out))
    else $error("received byte lost while stalled");
  AST_HOST_FREE: assert property (
    $rose(hst_sda_oe) && scl |-> free_cnt >= 9'h0FA)
    else $error("start without idle bus");
endmodule : iebs_sva
`default_nettype wire

/* tb/i2c_enable_and_bus_state_control_tb.sv */
// Testbench joining device and host ends across the two-wire carrier
`timescale 1ns/1ns
`default_nettype none
module i2c_enable_and_bus_state_control_tb;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic en, opt, wt, sie, spr, tx_valid, tx_last, rx_ready;
  logic [7:0] dcs, tx_data, rxd;
  logic busy, tirq, sirq, sseen, rxv, txr, nack, hbusy;
  logic [3:0] irq_q[$];
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int starts = 0;
  int stops = 0;
  int nacks = 0;
  iebs_if bus();
  iebs_device i_iebs_device(.clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus(bus),
    .interface_enable_bit_in(en), .startup_bus_free_option_in(opt), .wait_timing_bit_in(wt),
    .stop_irq_enable_bit_in(sie), .stop_request_bit_in(spr), .division_clock_select_1_in(dcs),
    .bus_busy_flag_out(busy), .transfer_irq_out(tirq), .stop_irq_out(sirq), .start_seen_out(sseen),
    .rx_valid_out(rxv), .rx_data_out(rxd), .rx_ready_in(rx_ready));
  iebs_host i_iebs_host(.clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus(bus), .tx_valid_in(tx_valid),
    .tx_data_in(tx_data), .tx_last_in(tx_last), .tx_ready_out(txr), .nack_out(nack), .busy_out(hbusy));
  iebs_sva i_iebs_sva(.clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl(bus.scl), .sda(bus.sda),
    .dev_scl_oe(bus.dev_scl_oe), .dev_sda_oe(bus.dev_sda_oe), .hst_sda_oe(bus.hst_sda_oe),
    .interface_enable_bit_in(en), .startup_bus_free_option_in(opt), .wait_timing_bit_in(wt),
    .stop_irq_enable_bit_in(sie), .bus_busy_flag_out(busy), .transfer_irq_out(tirq), .stop_irq_out(sirq),
    .start_seen_out(sseen), .rx_valid_out(rxv), .rx_data_out(rxd), .rx_ready_in(rx_ready));
  always #10 clk_in = ~clk_in;
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // Event monitor and hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (tirq === 1'b1) irq_q.push_back(i_iebs_sva.bit_idx);
    if (sseen === 1'b1) starts++;
    if (sirq === 1'b1) stops++;
    if (nack === 1'b1) nacks++;
    if (cyc == 40000) begin
      error_cnt++;
      close_out();
    end
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task cyc_n(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc_n
  task send(input logic [7:0] d, input logic l);
    int k;
    k = 0;
    @(posedge clk_in);
    tx_valid <= 1'b1;
    tx_data <= d;
    tx_last <= l;
    do begin
      @(posedge clk_in);
      k++;
    end while (txr !== 1'b1 && k < 5000);
    tx_valid <= 1'b0;
  endtask : send
  task pop(input logic [7:0] exp);
    int k;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (rxv !== 1'b1 && k < 5000);
    check(rxd, exp);
    rx_ready <= 1'b1;
    @(posedge clk_in);
    rx_ready <= 1'b0;
  endtask : pop
  // Lets the stop travel through the link synchronisers
  task done_wait;
    int k;
    k = 0;
    cyc_n(4);
    while (hbusy !== 1'b0 && k < 20000) begin
      @(posedge clk_in);
      k++;
    end
    cyc_n(100);
  endtask : done_wait
  // Option only taken while disabled, so drop enable first
  task enable(input logic o);
    @(posedge clk_in) en <= 1'b0;
    cyc_n(60);
    opt <= o;
    cyc_n(60);
    en <= 1'b1; // lines idle here
    cyc_n(3);
  endtask : enable
  initial begin
    en = 1'b0;
    opt = 1'b0;
    wt = 1'b1;
    sie = 1'b1;
    spr = 1'b0;
    dcs = 8'h00;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    tx_last = 1'b0;
    rx_ready = 1'b0;
    cyc_n(2);
    sys_rst_in <= 1'b0;
    cyc_n(40);
    enable(1'b0);
    check({7'h00, busy}, 8'h01);
    irq_q.delete();
    send(8'hA5, 1'b1);
    done_wait();
    check(8'(irq_q.size()), 8'h01);
    check({4'h0, irq_q[0]}, 8'h09);
    check(8'(starts), 8'h01);
    check(8'(stops), 8'h01);
    check({7'h00, busy}, 8'h00);
    pop(8'hA5);
    $display("test 1 done");
    wt <= 1'b0;
    // Stop event masked here: busy must still clear on the stop
    sie <= 1'b0;
    stops = 0;
    enable(1'b1);
    check({7'h00, busy}, 8'h00);
    irq_q.delete();
    send(8'hF0, 1'b0);
    send(8'h3C, 1'b0);
    send(8'h81, 1'b1);
    cyc_n(1500);
    // Full buffer must stretch the clock, not drop the third byte
    check({5'h00, bus.dev_scl_oe, rxv, bus.scl}, 8'h06);
    pop(8'hF0);
    pop(8'h3C);
    pop(8'h81);
    done_wait();
    check({4'h0, irq_q[0]}, 8'h08);
    check({4'h0, irq_q[1]}, 8'h09);
    check({4'h0, irq_q[2]}, 8'h09);
    check(8'(stops), 8'h00);
    check({7'h00, busy}, 8'h00);
    $display("test 2 done");
    @(posedge clk_in) en <= 1'b0;
    cyc_n(60);
    spr <= 1'b1;
    @(posedge clk_in) spr <= 1'b0;
    irq_q.delete();
    starts = 0;
    nacks = 0;
    send(8'h5A, 1'b1);
    done_wait();
    check(8'(starts), 8'h00);
    check(8'(irq_q.size()), 8'h00);
    check(8'(nacks), 8'h01);
    check({6'h00, busy, rxv}, 8'h00);
    $display("test 3 done");
    close_out();
  end
endmodule : i2c_enable_and_bus_state_control_tb
`default_nettype wire
